// [rr_exec_pkg.sv]
// shared constants for the return and rotate execution block
package rr_exec_pkg;
  localparam int DATA_W = 8;
  localparam int PC_W = 21;
  localparam int FADDR_W = 8;
  localparam int BANK_W = 4;
  localparam int DADDR_W = 12;
  localparam int STATUS_W = 5;
  // flag bit positions in the status register
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 2;
  localparam int FLAG_N = 4;
  // opcode layout
  localparam logic [15:0] RETURN_MASK = 16'hFFFE;
  localparam logic [15:0] RETURN_CODE = 16'h0012;
  localparam int FAST_BIT = 0;
  localparam logic [5:0] ROT_LEFT_CARRY = 6'h0D;
  localparam logic [5:0] ROT_LEFT_PLAIN = 6'h11;
  localparam logic [5:0] ROT_RIGHT_CARRY = 6'h0C;
  localparam logic [5:0] ROT_RIGHT_PLAIN = 6'h10;
  localparam int OPC_HI = 15;
  localparam int OPC_LO = 10;
  localparam int DEST_BIT = 9;
  localparam int ACCESS_BIT = 8;
  // access bank split: low half maps to bank 0, upper half to bank 15
  localparam int ACCESS_SPLIT_BIT = 7;
  localparam logic [BANK_W-1:0] ACCESS_LOW_BANK = 4'h0;
  localparam logic [BANK_W-1:0] ACCESS_HIGH_BANK = 4'hF;
  // Avalon register map (word addresses)
  localparam logic [1:0] ADDR_WORKING = 2'h0;
  localparam logic [1:0] ADDR_STATUS = 2'h1;
  localparam logic [1:0] ADDR_BANK = 2'h2;
  localparam logic [1:0] ADDR_SHADOW = 2'h3;
  localparam logic [31:0] UNMAPPED_READ = 32'h00000000;
  typedef enum logic [1:0] {Q1, Q2, Q3, Q4} phase_t;
  typedef enum {OP_NONE, OP_RET, OP_RLC, OP_RLP, OP_RRC, OP_RRP} op_t;
endpackage

// [phase_counter.sv]
// four-phase instruction cycle sequencer
`timescale 1ns/10ps
module phase_counter
  import rr_exec_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  output phase_t phase,
  output logic cycleEnd
);
  phase_t phase_reg;
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      phase_reg <= Q1;
    end else begin
      case (phase_reg)
        Q1: phase_reg <= Q2;
        Q2: phase_reg <= Q3;
        Q3: phase_reg <= Q4;
        Q4: phase_reg <= Q1;
        default: phase_reg <= Q1;
      endcase
    end
  end
  assign phase = phase_reg;
  assign cycleEnd = (phase_reg == Q4);
endmodule // phase_counter

// [rotate_unit.sv]
// 8-bit rotate datapath with flag results
`timescale 1ns/10ps
module rotate_unit
  import rr_exec_pkg::*;
#(
  parameter int WIDTH = DATA_W
) (
  input wire logic [WIDTH-1:0] operand,
  input wire logic carryIn,
  input wire logic goLeft,
  input wire logic throughCarry,
  output logic [WIDTH-1:0] result,
  output logic carryOut,
  output logic negOut,
  output logic zeroOut
);
  logic fillBit;
  always_comb begin
    if (goLeft) begin
      fillBit = throughCarry ? carryIn : operand[WIDTH-1];
      result = {operand[WIDTH-2:0], fillBit};
      carryOut = throughCarry ? operand[WIDTH-1] : carryIn;
    end else begin
      fillBit = throughCarry ? carryIn : operand[0];
      result = {fillBit, operand[WIDTH-1:1]};
      carryOut = throughCarry ? operand[0] : carryIn;
    end
    negOut = result[WIDTH-1];
    zeroOut = (result == '0);
  end
endmodule // rotate_unit

// [return_and_rotate_exec.sv]
// return and rotate execution with Avalon register window
`timescale 1ns/10ps
//
// Notes on behaviour
// - a return pops the stack and loads the popped top entry into the program counter.
// - a return with the fast bit set restores working, flag and bank registers from shadows.
// - a return with the fast bit clear leaves working, flag and bank registers alone.
// - a return never changes the upper or high program-counter latches.
// - a return is two cycles: pop in Q4 of the first, nothing in the second.
// - rotate left through carry moves bit 7 to carry and old carry to bit 0, updating C, N, Z.
// - rotate left plain moves bit 7 to bit 0, updating N and Z only.
// - rotate right through carry moves bit 0 to carry and old carry to bit 7, updating C, N, Z.
// - destination bit 0 writes the working register, 1 writes the file register.
// - access bit 0 addresses the access bank ignoring the bank register.
// - access bit 1 forms the address from the bank register and the file field.
// - a rotate is one cycle: decode Q1, read Q2, process Q3, write Q4.
module return_and_rotate_exec
  import rr_exec_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [15:0] opcode,
  input wire logic opcodeValid,
  input wire logic [PC_W-1:0] stackTopEntry,
  input wire logic [DATA_W-1:0] fileReadData,
  input wire logic [PC_W-1:0] pcIn,
  input wire logic [PC_W-1:0] pcUpperLatchIn,
  input wire logic [1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic opcodeTaken,
  output logic stackPop,
  output logic pcLoad,
  output logic [PC_W-1:0] pcValue,
  output logic fileRead,
  output logic fileWrite,
  output logic [DADDR_W-1:0] fileAddr,
  output logic [DATA_W-1:0] fileWriteData,
  output logic [DATA_W-1:0] workingRegister,
  output logic [STATUS_W-1:0] flagRegister,
  output logic [BANK_W-1:0] bankSelectRegister,
  output logic [1:0] execPhase
);
  ////////////////////////////////////////////////////////////////////////////
  phase_t phase;
  logic cycleEnd;
  phase_counter u_phase (
    .clock(clock),
    .rst_b(rst_b),
    .phase(phase),
    .cycleEnd(cycleEnd)
  );

  ////////////////////////////////////////////////////////////////////////////
  // decode, latched in Q1
  op_t op_reg;
  logic busy_reg;
  logic secondCycle_reg;
  logic fast_reg;
  logic destFile_reg;
  logic [DADDR_W-1:0] addr_reg;
  logic [DATA_W-1:0] operand_reg;
  logic [DATA_W-1:0] result_reg;
  logic [DATA_W-1:0] workingRegister_reg;
  logic [STATUS_W-1:0] flagRegister_reg;
  logic [BANK_W-1:0] bankSelectRegister_reg;
  logic [DATA_W-1:0] workingShadow_reg;
  logic [STATUS_W-1:0] flagShadow_reg;
  logic [BANK_W-1:0] bankSelectShadow_reg;
  op_t opDecoded;
  logic [DADDR_W-1:0] addrDecoded;
  logic [FADDR_W-1:0] fField;

  always_comb begin
    fField = opcode[FADDR_W-1:0];
    opDecoded = OP_NONE;
    if ((opcode & RETURN_MASK) == RETURN_CODE) begin
      opDecoded = OP_RET;
    end else begin
      case (opcode[OPC_HI:OPC_LO])
        ROT_LEFT_CARRY: opDecoded = OP_RLC;
        ROT_LEFT_PLAIN: opDecoded = OP_RLP;
        ROT_RIGHT_CARRY: opDecoded = OP_RRC;
        ROT_RIGHT_PLAIN: opDecoded = OP_RRP;
        default: opDecoded = OP_NONE;
      endcase
    end
    if (opcode[ACCESS_BIT]) begin
      addrDecoded = {bankSelectRegister_reg, fField};
    end else if (fField[ACCESS_SPLIT_BIT]) begin
      addrDecoded = {ACCESS_HIGH_BANK, fField};
    end else begin
      addrDecoded = {ACCESS_LOW_BANK, fField};
    end
  end

  wire logic isRotate = (op_reg == OP_RLC) || (op_reg == OP_RLP) || (op_reg == OP_RRC) || (op_reg == OP_RRP);
  wire logic rotDecoded = (opDecoded == OP_RLC) || (opDecoded == OP_RLP) || (opDecoded == OP_RRC) || (opDecoded == OP_RRP);
  wire logic rotTaken = (phase == Q1) && !secondCycle_reg && opcodeValid && rotDecoded;

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      op_reg <= OP_NONE;
      busy_reg <= 1'b0;
      secondCycle_reg <= 1'b0;
      fast_reg <= 1'b0;
      destFile_reg <= 1'b1;
      addr_reg <= '0;
      opcodeTaken <= 1'b0;
    end else begin
      opcodeTaken <= 1'b0;
      if (phase == Q1 && !secondCycle_reg) begin
        op_reg <= opcodeValid ? opDecoded : OP_NONE;
        busy_reg <= opcodeValid && (opDecoded != OP_NONE);
        fast_reg <= opcode[FAST_BIT];
        destFile_reg <= opcode[DEST_BIT];
        addr_reg <= addrDecoded;
        opcodeTaken <= opcodeValid;
      end else if (phase == Q1) begin
        op_reg <= OP_NONE;
      end
      if (cycleEnd) begin
        secondCycle_reg <= (op_reg == OP_RET);
        if (op_reg != OP_RET) begin
          busy_reg <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // rotate datapath: read Q2, process Q3, write Q4
  logic [DATA_W-1:0] rotResult;
  logic rotCarry;
  logic rotNeg;
  logic rotZero;
  logic rotCarry_reg;
  logic rotNeg_reg;
  logic rotZero_reg;
  rotate_unit #(.WIDTH(DATA_W)) u_rot (
    .operand(operand_reg),
    .carryIn(flagRegister_reg[FLAG_C]),
    .goLeft((op_reg == OP_RLC) || (op_reg == OP_RLP)),
    .throughCarry((op_reg == OP_RLC) || (op_reg == OP_RRC)),
    .result(rotResult),
    .carryOut(rotCarry),
    .negOut(rotNeg),
    .zeroOut(rotZero)
  );

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      operand_reg <= '0;
      result_reg <= '0;
      rotCarry_reg <= 1'b0;
      rotNeg_reg <= 1'b0;
      rotZero_reg <= 1'b0;
    end else begin
      if (phase == Q2 && isRotate) begin
        operand_reg <= fileReadData;
      end
      if (phase == Q3 && isRotate) begin
        result_reg <= rotResult;
        rotCarry_reg <= rotCarry;
        rotNeg_reg <= rotNeg;
        rotZero_reg <= rotZero;
      end
    end
  end

  // file port strobes, registered so they line up with Q2 and Q4
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      fileRead <= 1'b0;
      fileWrite <= 1'b0;
      fileAddr <= '0;
      fileWriteData <= '0;
    end else begin
      // op_reg is still the previous instruction at the Q1 edge, so read off the decode
      fileRead <= rotTaken;
      fileWrite <= (phase == Q3) && isRotate && destFile_reg;
      if (rotTaken) begin
        fileAddr <= addrDecoded;
      end
      fileWriteData <= rotResult;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // return: pop and load the counter in Q4 of the first cycle
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      stackPop <= 1'b0;
      pcLoad <= 1'b0;
      pcValue <= '0;
    end else begin
      stackPop <= (phase == Q3) && (op_reg == OP_RET) && !secondCycle_reg;
      pcLoad <= (phase == Q3) && (op_reg == OP_RET) && !secondCycle_reg;
      pcValue <= stackTopEntry;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // architectural registers; bus writes only when no instruction is active
  wire logic retWrite = cycleEnd && (op_reg == OP_RET) && !secondCycle_reg;
  wire logic rotWrite = cycleEnd && isRotate;
  wire logic busWrite = avs_write && !avs_waitrequest;

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      workingRegister_reg <= '0;
    end else if (retWrite && fast_reg) begin
      workingRegister_reg <= workingShadow_reg;
    end else if (rotWrite && !destFile_reg) begin
      workingRegister_reg <= result_reg;
    end else if (busWrite && avs_address == ADDR_WORKING && avs_byteenable[0]) begin
      workingRegister_reg <= avs_writedata[DATA_W-1:0];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      flagRegister_reg <= '0;
    end else if (retWrite && fast_reg) begin
      flagRegister_reg <= flagShadow_reg;
    end else if (rotWrite) begin
      flagRegister_reg[FLAG_C] <= rotCarry_reg;
      flagRegister_reg[FLAG_N] <= rotNeg_reg;
      flagRegister_reg[FLAG_Z] <= rotZero_reg;
    end else if (busWrite && avs_address == ADDR_STATUS && avs_byteenable[0]) begin
      flagRegister_reg <= avs_writedata[STATUS_W-1:0];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      bankSelectRegister_reg <= '0;
    end else if (retWrite && fast_reg) begin
      bankSelectRegister_reg <= bankSelectShadow_reg;
    end else if (busWrite && avs_address == ADDR_BANK && avs_byteenable[0]) begin
      bankSelectRegister_reg <= avs_writedata[BANK_W-1:0];
    end
  end

  // shadow copies loaded by software: byte 0 working, 1 flags, 2 bank
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      workingShadow_reg <= '0;
      flagShadow_reg <= '0;
      bankSelectShadow_reg <= '0;
    end else if (busWrite && avs_address == ADDR_SHADOW) begin
      if (avs_byteenable[0]) begin
        workingShadow_reg <= avs_writedata[7:0];
      end
      if (avs_byteenable[1]) begin
        flagShadow_reg <= avs_writedata[8 +: STATUS_W];
      end
      if (avs_byteenable[2]) begin
        bankSelectShadow_reg <= avs_writedata[16 +: BANK_W];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Avalon slave: one wait cycle, stalls while an instruction is in flight
  logic accepted_reg;
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      avs_waitrequest <= 1'b1;
      accepted_reg <= 1'b0;
      avs_readdata <= UNMAPPED_READ;
    end else begin
      accepted_reg <= 1'b0;
      avs_waitrequest <= 1'b1;
      if ((avs_read || avs_write) && avs_waitrequest && !accepted_reg && !busy_reg && opcodeValid == 1'b0) begin
        avs_waitrequest <= 1'b0;
        accepted_reg <= 1'b1;
        case (avs_address)
          ADDR_WORKING: avs_readdata <= {24'h000000, workingRegister_reg};
          ADDR_STATUS: avs_readdata <= {27'h0000000, flagRegister_reg};
          ADDR_BANK: avs_readdata <= {28'h0000000, bankSelectRegister_reg};
          ADDR_SHADOW: avs_readdata <= {12'h000, bankSelectShadow_reg, 3'h0, flagShadow_reg, workingShadow_reg};
          default: avs_readdata <= UNMAPPED_READ;
        endcase
      end
    end
  end

  assign workingRegister = workingRegister_reg;
  assign flagRegister = flagRegister_reg;
  assign bankSelectRegister = bankSelectRegister_reg;
  assign execPhase = phase;

  ////////////////////////////////////////////////////////////////////////////
  sequence s_retTaken;
    phase == Q1 && !secondCycle_reg && opcodeValid && opDecoded == OP_RET;
  endsequence

  a_return_pops_q4: assert property (@(posedge clock) disable iff (!rst_b)
    s_retTaken |-> ##3 (stackPop && pcLoad && pcValue == $past(stackTopEntry)))
    else $error("return did not pop in Q4");
  a_return_second_idle: assert property (@(posedge clock) disable iff (!rst_b)
    s_retTaken |-> ##4 (!stackPop [*4]))
    else $error("return second cycle not idle");
  a_fast_restore_working: assert property (@(posedge clock) disable iff (!rst_b)
    (retWrite && fast_reg) |=> (workingRegister_reg == $past(workingShadow_reg)))
    else $error("fast return did not restore working");
  a_slow_keeps_regs: assert property (@(posedge clock) disable iff (!rst_b)
    (retWrite && !fast_reg) |=> $stable(workingRegister_reg) && $stable(flagRegister_reg) && $stable(bankSelectRegister_reg))
    else $error("plain return changed registers");
  a_plain_keeps_carry: assert property (@(posedge clock) disable iff (!rst_b)
    (rotWrite && (op_reg == OP_RLP || op_reg == OP_RRP)) |=> $stable(flagRegister_reg[FLAG_C]))
    else $error("plain rotate changed carry");
  a_zero_flag_match: assert property (@(posedge clock) disable iff (!rst_b)
    rotWrite |=> (flagRegister_reg[FLAG_Z] == ($past(result_reg) == '0)))
    else $error("zero flag wrong after rotate");
  a_file_write_dest: assert property (@(posedge clock) disable iff (!rst_b)
    fileWrite |-> phase == Q4 && destFile_reg)
    else $error("file write outside Q4 or wrong destination");
  a_access_bank_addr: assert property (@(posedge clock) disable iff (!rst_b)
    (phase == Q1 && !opcode[ACCESS_BIT]) |-> addrDecoded == {(opcode[ACCESS_SPLIT_BIT] ? ACCESS_HIGH_BANK : ACCESS_LOW_BANK),
      opcode[FADDR_W-1:0]})
    else $error("access bank used bank register");
  a_banked_addr: assert property (@(posedge clock) disable iff (!rst_b)
    (phase == Q1 && opcode[ACCESS_BIT]) |-> addrDecoded == {bankSelectRegister_reg, opcode[FADDR_W-1:0]})
    else $error("banked address wrong");
  a_read_in_q2: assert property (@(posedge clock) disable iff (!rst_b)
    fileRead |-> phase == Q2)
    else $error("file read outside Q2");

  sequence s_rotTaken;
    rotTaken;
  endsequence

  a_rotate_read_write: assert property (@(posedge clock) disable iff (!rst_b)
    s_rotTaken |-> ##1 (fileRead && fileAddr == addr_reg) ##2 (fileWrite == destFile_reg))
    else $error("rotate read or write out of phase");
  a_carry_left_through: assert property (@(posedge clock) disable iff (!rst_b)
    (rotWrite && op_reg == OP_RLC) |=> (flagRegister_reg[FLAG_C] == $past(operand_reg[DATA_W-1])))
    else $error("left rotate carry wrong");
  a_carry_right_through: assert property (@(posedge clock) disable iff (!rst_b)
    (rotWrite && op_reg == OP_RRC) |=> (flagRegister_reg[FLAG_C] == $past(operand_reg[0])))
    else $error("right rotate carry wrong");
  a_neg_flag_match: assert property (@(posedge clock) disable iff (!rst_b)
    rotWrite |=> (flagRegister_reg[FLAG_N] == $past(result_reg[DATA_W-1])))
    else $error("negative flag wrong after rotate");
endmodule // return_and_rotate_exec

// [return_and_rotate_exec_test.sv]
// self-checking bench for the return and rotate execution block
`timescale 1ns/10ps
module return_and_rotate_exec_test;
  import rr_exec_pkg::*;
  logic clock;
  logic rst_b;
  logic [15:0] opcode;
  logic opcodeValid;
  logic [PC_W-1:0] stackTopEntry;
  logic [DATA_W-1:0] fileReadData;
  logic [PC_W-1:0] pcIn;
  logic [PC_W-1:0] pcUpperLatchIn;
  logic [1:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic opcodeTaken;
  logic stackPop;
  logic pcLoad;
  logic [PC_W-1:0] pcValue;
  logic fileRead;
  logic fileWrite;
  logic [DADDR_W-1:0] fileAddr;
  logic [DATA_W-1:0] fileWriteData;
  logic [DATA_W-1:0] workingRegister;
  logic [STATUS_W-1:0] flagRegister;
  logic [BANK_W-1:0] bankSelectRegister;
  logic [1:0] execPhase;
  int bad_count;
  int check_count;
  int nRd, nWr, nPop, nLoad, nTake;
  logic phaseOk;
  logic [DADDR_W-1:0] rdAddr;
  logic [DATA_W-1:0] wrData;
  logic [PC_W-1:0] popValue;
  logic [31:0] rdBack;

  return_and_rotate_exec dut_u (.clock(clock), .rst_b(rst_b), .opcode(opcode), .opcodeValid(opcodeValid),
    .stackTopEntry(stackTopEntry), .fileReadData(fileReadData), .pcIn(pcIn), .pcUpperLatchIn(pcUpperLatchIn),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .opcodeTaken(opcodeTaken), .stackPop(stackPop), .pcLoad(pcLoad), .pcValue(pcValue), .fileRead(fileRead),
    .fileWrite(fileWrite), .fileAddr(fileAddr), .fileWriteData(fileWriteData), .workingRegister(workingRegister),
    .flagRegister(flagRegister), .bankSelectRegister(bankSelectRegister), .execPhase(execPhase));

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  ////////////////////////////////////////////////////////////////////////
  task end_sim;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] expv);
    check_count++;
    if (seen !== expv) begin
      bad_count++;
      $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, expv);
    end
  endtask

  // request held until the edge that samples waitrequest low
  task bus_access(input logic wr, input logic [1:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    for (n = 0; n < 200; n++) begin
      @(posedge clock);
      if (avs_waitrequest === 1'b0) break;
    end
    if (n == 200) begin
      bad_count++;
      end_sim();
    end
    rdBack = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  // launch at the Q1 edge, then watch eight cycles (two instruction cycles)
  task run_op(input logic [15:0] op, input logic [7:0] fdata);
    int n;
    for (n = 0; n < 20; n++) begin
      @(posedge clock);
      if (execPhase === 2'h3) break;
    end
    if (n == 20) begin
      bad_count++;
      end_sim();
    end
    opcode <= op;
    opcodeValid <= 1'b1;
    fileReadData <= fdata;
    nRd = 0; nWr = 0; nPop = 0; nLoad = 0; nTake = 0;
    phaseOk = 1'b1;
    @(posedge clock);
    opcodeValid <= 1'b0;
    for (n = 0; n < 8; n++) begin
      #1;
      if (opcodeTaken === 1'b1) nTake++;
      if (fileRead === 1'b1) begin
        nRd++;
        rdAddr = fileAddr;
        if (execPhase !== 2'h1 || n != 0) phaseOk = 1'b0;
      end
      if (fileWrite === 1'b1) begin
        nWr++;
        wrData = fileWriteData;
        if (execPhase !== 2'h3 || fileAddr !== rdAddr) phaseOk = 1'b0;
      end
      if (stackPop === 1'b1) begin
        nPop++;
        popValue = pcValue;
        if (execPhase !== 2'h3 || pcLoad !== 1'b1) phaseOk = 1'b0;
      end
      if (pcLoad === 1'b1) nLoad++;
      @(posedge clock);
    end
  endtask

  // kind: 0 left carry, 1 left plain, 2 right carry, 3 right plain; returns {carry, result}
  function automatic logic [8:0] rot(input logic [1:0] kind, input logic [7:0] v, input logic c);
    case (kind)
      2'd0: rot = {v[7], v[6:0], c};
      2'd1: rot = {c, v[6:0], v[7]};
      2'd2: rot = {v[0], c, v[7:1]};
      default: rot = {c, v[0], v[7:1]};
    endcase
  endfunction

  task rot_case(input logic [1:0] kind, input logic d, input logic a, input logic [7:0] f, input logic [7:0] data,
    input logic [4:0] st);
    logic [5:0] opc;
    logic [8:0] r;
    logic [4:0] expSt;
    opc = (kind == 2'd0) ? ROT_LEFT_CARRY : (kind == 2'd1) ? ROT_LEFT_PLAIN :
      (kind == 2'd2) ? ROT_RIGHT_CARRY : ROT_RIGHT_PLAIN;
    r = rot(kind, data, st[FLAG_C]);
    expSt = st;
    expSt[FLAG_C] = r[8];
    expSt[FLAG_N] = r[7];
    expSt[FLAG_Z] = (r[7:0] == 8'h00);
    bus_access(1'b1, ADDR_WORKING, 32'h0000003C);
    bus_access(1'b1, ADDR_STATUS, {27'h0, st});
    run_op({opc, d, a, f}, data);
    chk(nRd, 1);
    chk(phaseOk, 1'b1);
    chk(nPop, 0);
    if (a) begin
      chk(rdAddr, {4'h9, f});
    end else begin
      chk(rdAddr, {(f[7] ? ACCESS_HIGH_BANK : ACCESS_LOW_BANK), f});
    end
    chk(nWr, d);
    if (d) chk(wrData, r[7:0]);
    chk(workingRegister, d ? 8'h3C : r[7:0]);
    chk(flagRegister[FLAG_C], expSt[FLAG_C]);
    chk(flagRegister, expSt);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    rst_b = 1'b0;
    opcode = 16'h0000;
    opcodeValid = 1'b0;
    stackTopEntry = 21'h000000;
    fileReadData = 8'h00;
    pcIn = 21'h000000;
    pcUpperLatchIn = 21'h000000;
    avs_address = 2'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h00000000;
    avs_byteenable = 4'hF;
    bad_count = 0;
    check_count = 0;
    repeat (3) @(posedge clock);
    #1;
    chk(avs_waitrequest, 1'b1);
    chk({stackPop, pcLoad, fileRead, fileWrite, opcodeTaken}, 5'h00);
    chk({workingRegister, flagRegister, bankSelectRegister}, 17'h00000);
    @(posedge clock);
    rst_b <= 1'b1;
    $display("test reset done");
    bus_access(1'b1, ADDR_WORKING, 32'h0000005A);
    bus_access(1'b1, ADDR_STATUS, 32'h0000000A);
    bus_access(1'b1, ADDR_BANK, 32'h00000003);
    bus_access(1'b1, ADDR_SHADOW, 32'h000915C3);
    bus_access(1'b0, ADDR_SHADOW, 32'h00000000);
    chk(rdBack, 32'h000915C3);
    bus_access(1'b0, ADDR_WORKING, 32'h00000000);
    chk(rdBack, 32'h0000005A);
    $display("test registers done");
    stackTopEntry <= 21'h1ABCD;
    run_op(RETURN_CODE, 8'h00);
    chk(nTake, 1);
    chk(nPop, 1);
    chk(nLoad, 1);
    chk(popValue, 21'h1ABCD);
    chk(phaseOk, 1'b1);
    chk(nRd + nWr, 0);
    chk({workingRegister, flagRegister, bankSelectRegister}, {8'h5A, 5'h0A, 4'h3});
    stackTopEntry <= 21'h0F00F;
    run_op(RETURN_CODE | 16'h0001, 8'h00);
    chk(nPop, 1);
    chk(popValue, 21'h0F00F);
    chk({workingRegister, flagRegister, bankSelectRegister}, {8'hC3, 5'h15, 4'h9});
    $display("test returns done");
    rot_case(2'd0, 1'b1, 1'b0, 8'h20, 8'hE6, 5'h00);
    rot_case(2'd1, 1'b0, 1'b1, 8'h45, 8'hAB, 5'h01);
    rot_case(2'd2, 1'b1, 1'b0, 8'h90, 8'h01, 5'h00);
    rot_case(2'd3, 1'b0, 1'b1, 8'h10, 8'hD7, 5'h00);
    rot_case(2'd0, 1'b0, 1'b1, 8'hFF, 8'h80, 5'h0A);
    rot_case(2'd2, 1'b1, 1'b0, 8'h7F, 8'h00, 5'h01);
    rot_case(2'd1, 1'b1, 1'b0, 8'h80, 8'h00, 5'h1F);
    rot_case(2'd3, 1'b1, 1'b1, 8'h00, 8'h01, 5'h00);
    $display("test rotates done");
    end_sim();
  end
endmodule // return_and_rotate_exec_test
